// *** bench/spi_host_model.sv ***
// Host controller model driving the serial link of the guard
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic i_so,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_si
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si   = 1'b0;
  end

  // Bits leave MSB first; the link clock runs only inside a frame
  task automatic frame(input logic [39:0] data, input int nbits,
                       output logic [7:0] rd);
    rd = 8'h00;
    #3.3;
    o_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      o_si = data[39-i];                 // Changed while clock low
      #7.5 o_sclk = 1'b1;
      if (i >= 8 && i < 16) rd = {rd[6:0], i_so};  // Sampled rising
      #7.5 o_sclk = 1'b0;
    end
    #7.5 o_cs_n = 1'b1;                  // Raised half a clock period after the last falling edge
    o_si = ~o_si;                        // Released line shows no stale bit
  endtask : frame
endmodule : spi_host_model

// *** bench/tb_flash_write_guard.sv ***
// Self-checking bench for the flash write guard
`timescale 1ns/1ps
`include "wp_consts.svh"
module tb_flash_write_guard;
  logic           i_clk_sys, i_rst_n, i_sclk, i_cs_n, i_si;
  logic           i_factory_lock, i_top_bottom;
  logic [3:0]     i_protect_level_bits;
  logic           o_so, o_so_en_n, o_reject, o_write_enable_latch;
  logic           o_deep_sleep, o_secure_mode;
  logic [1:0]     o_security_reg;
  wp_pkg::grant_s o_grant;
  int             err_count, samples_checked;
  logic [7:0]     rd;
  logic [23:0]    addr;
  int             n, blk, rnd;
  logic [3:0]     lv;
  logic           tbs, op_erase;
  logic           so_drv;

  // Output enable seen low at a sampling edge of the link
  always @(posedge i_sclk) begin
    if (!i_cs_n && o_so_en_n === 1'b0) so_drv = 1'b1;
  end

  flash_write_guard u_dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sclk(i_sclk),
    .i_cs_n(i_cs_n), .i_si(i_si), .i_factory_lock(i_factory_lock),
    .i_protect_level_bits(i_protect_level_bits),
    .i_top_bottom(i_top_bottom), .o_so(o_so), .o_so_en_n(o_so_en_n),
    .o_grant(o_grant), .o_reject(o_reject),
    .o_write_enable_latch(o_write_enable_latch),
    .o_deep_sleep(o_deep_sleep), .o_secure_mode(o_secure_mode),
    .o_security_reg(o_security_reg)
  );
  spi_host_model u_host (
    .i_so(o_so), .o_sclk(i_sclk), .o_cs_n(i_cs_n), .o_si(i_si)
  );

  initial i_clk_sys = 1'b0;
  always #5 i_clk_sys = ~i_clk_sys;

  task automatic chk(input string name, input logic [26:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  function automatic wp_pkg::grant_s mkg(logic er, logic otp, logic [23:0] a);
    return {1'b1, er, otp, a};
  endfunction : mkg

  function automatic logic prot_exp(logic [3:0] l, logic t, int b);
    int m;
    if (l == 4'h0) return 1'b0;
    if (l > 4'h8) return 1'b1;
    m = 1 << (l - 1);
    return t ? (b < m) : (b >= 256 - m);
  endfunction : prot_exp

  // Expected kind: 0 silent, 1 grant, 2 reject, 3 not judged
  task automatic cmd(input logic [39:0] d, input int nb, input logic [1:0] k,
                     input wp_pkg::grant_s eg);
    logic [1:0]     seen;
    wp_pkg::grant_s g;
    seen = 2'h0;
    g    = '0;
    so_drv = 1'b0;
    u_host.frame(d, nb, rd);
    chk("soen", {26'h0, d[39:32] == `OP_READ_SEC_REG},
        {26'h0, so_drv});
    repeat (10) begin  // Also keeps the chip-select gap well above 6 cycles
      @(negedge i_clk_sys);
      if (o_grant.valid === 1'b1) begin
        seen = 2'h1;
        g    = o_grant;
      end
      if (o_reject === 1'b1) seen = 2'h2;
    end
    if (k != 2'h3) chk("response", {25'h0, k}, {25'h0, seen});
    if (k == 2'h1) chk("grant", eg, g);
  endtask : cmd

  task automatic one(input logic [7:0] op, input logic [1:0] k);
    cmd({op, 32'h0}, 8, k, '0);
  endtask : one

  task automatic write_enable_cmd();
    one(`OP_WRITE_ENABLE, 2'h0);
    chk("latch", 27'h1, {26'h0, o_write_enable_latch});
  endtask : write_enable_cmd

  task automatic do_reset(input logic lock);
    @(negedge i_clk_sys);
    i_rst_n        = 1'b0;
    i_factory_lock = lock;
    repeat (10) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    repeat (8) @(negedge i_clk_sys);
    chk("idle", 27'h0, {o_write_enable_latch, o_deep_sleep, o_secure_mode});
    chk("secreg", {25'h0, 1'b0, lock}, {25'h0, o_security_reg});
  endtask : do_reset

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    #500000;  // Several times the expected run, well inside the budget
    err_count++;
    stop_test();
  end

  initial begin
    i_rst_n = 1'b0;
    i_factory_lock = 1'b0;
    i_protect_level_bits = 4'h0;
    i_top_bottom = 1'b0;
    err_count = 0;
    samples_checked = 0;
    rnd = $urandom(30270);
    do_reset(1'b0);
    cmd({`OP_PROGRAM, 32'h1234_0055}, 40, 2'h2, '0);
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'h1234_0055}, 36, 2'h2, '0);
    write_enable_cmd();
    cmd({`OP_ERASE_BLOCK, 32'h0100_0000}, 40, 2'h2, '0);
    for (int k = 0; k < 104; k++) begin
      lv  = (k < 64) ? k[3:0] : 4'($urandom_range(15, 0));
      tbs = (k < 64) ? k[4] : 1'($urandom);
      n   = (lv >= 4'h1 && lv <= 4'h8) ? (1 << (lv - 1)) : 128;
      blk = tbs ? n - 1 + k[5] : 256 - n - k[5];  // Region edge pairs
      if (k >= 64) blk = $urandom_range(255, 0);
      op_erase = 1'($urandom);
      addr = {8'(blk), 16'($urandom)};
      @(negedge i_clk_sys);
      i_protect_level_bits = lv;
      i_top_bottom = tbs;
      write_enable_cmd();
      cmd(op_erase ? {`OP_ERASE_BLOCK, addr, 8'h00}
                   : {`OP_PROGRAM, addr, 8'($urandom)},
          op_erase ? 32 : 40, prot_exp(lv, tbs, blk) ? 2'h2 : 2'h1,
          mkg(op_erase, 1'b0, addr));
    end
    i_protect_level_bits = 4'h0;
    one(`OP_ENTER_SECURE, 2'h0);
    chk("secure", 27'h1, {26'h0, o_secure_mode});
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'hABC1_FF5A}, 40, 2'h1, mkg(0, 1, 24'h0001FF));
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'h0002_00A5}, 40, 2'h1, mkg(0, 1, 24'h000200));
    write_enable_cmd();
    cmd({`OP_ERASE_BLOCK, 32'h0100_0000}, 32, 2'h2, '0);
    write_enable_cmd();
    one(`OP_WRITE_SEC_REG, 2'h3);
    chk("custlock", 27'h2, {25'h0, o_security_reg});
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'hFFF0_1000}, 40, 2'h2, '0);
    one(`OP_EXIT_SECURE, 2'h0);
    chk("secure", 27'h0, {26'h0, o_secure_mode});
    cmd({`OP_READ_SEC_REG, 32'h0}, 16, 2'h0, '0);
    chk("secread", 27'h2, {19'h0, rd});
    one(`OP_WRITE_DISABLE, 2'h0);
    chk("latch", 27'h0, {26'h0, o_write_enable_latch});
    one(`OP_DEEP_SLEEP, 2'h0);
    chk("sleep", 27'h1, {26'h0, o_deep_sleep});
    one(`OP_WRITE_ENABLE, 2'h2);
    chk("latch", 27'h0, {26'h0, o_write_enable_latch});
    one(`OP_RELEASE_SLEEP, 2'h0);
    chk("sleep", 27'h0, {26'h0, o_deep_sleep});
    one(`OP_DEEP_SLEEP, 2'h0);
    one(`OP_SOFT_RESET, 2'h0);
    chk("sleep", 27'h0, {26'h0, o_deep_sleep});
    do_reset(1'b1);
    one(`OP_ENTER_SECURE, 2'h0);
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'h0003_FF11}, 40, 2'h2, '0);
    write_enable_cmd();
    cmd({`OP_PROGRAM, 32'hFFF1_FF22}, 40, 2'h1, mkg(0, 1, 24'h0001FF));
    cmd({`OP_READ_SEC_REG, 32'h0}, 16, 2'h0, '0);
    chk("secread", 27'h1, {19'h0, rd});
    stop_test();
  end
endmodule : tb_flash_write_guard

// *** design/flash_write_guard.sv ***
// Write-protection and command filter of a serial NOR flash
`timescale 1ns/1ps
`include "wp_consts.svh"
module flash_write_guard (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst_n,
  input  wire logic       i_sclk,
  input  wire logic       i_cs_n,
  input  wire logic       i_si,
  input  wire logic       i_factory_lock,
  input  wire logic [3:0] i_protect_level_bits,
  input  wire logic       i_top_bottom,
  output logic            o_so,
  output logic            o_so_en_n,
  output wp_pkg::grant_s  o_grant,
  output logic            o_reject,
  output logic            o_write_enable_latch,
  output logic            o_deep_sleep,
  output logic            o_secure_mode,
  output logic [1:0]      o_security_reg
);
  // Link side, serial clock domain
  logic        first_q;
  logic [2:0]  bit_q,  bit_d;
  logic [2:0]  nbyte_q, nbyte_d;
  logic [31:0] sh_q,   sh_d;
  logic [7:0]  op_q,   op_d;
  logic [23:0] addr_q, addr_d;
  logic        so_q,   so_d;
  logic        so_en_n_q, so_en_n_d;
  logic [1:0]  sec_l;
  logic [7:0]  sec_byte;
  logic [2:0]  cur_bit;
  logic [2:0]  cur_nb;

  // System side
  logic              rst_q;
  logic [6:0]        pin_s;
  logic              cs_s;
  logic              fac_s;
  logic              tb_s;
  logic [3:0]        lvl_s;
  logic              cs_prev_q, cs_prev_d;
  logic              cs_rise;
  wp_pkg::guard_st_e st_q, st_d;
  logic [2:0]        sn_bit_q, sn_bit_d;
  logic [2:0]        sn_nb_q,  sn_nb_d;
  logic [7:0]        sn_op_q,  sn_op_d;
  logic [23:0]       sn_addr_q, sn_addr_d;
  logic              wel_q, wel_d;
  logic              sleep_q, sleep_d;
  logic              secure_q, secure_d;
  logic [1:0]        boot_q, boot_d;
  logic              fac_lock_q, fac_lock_d;
  logic              cust_lock_q, cust_lock_d;
  wp_pkg::grant_s    grant_q, grant_d;
  logic              reject_q, reject_d;
  logic              whole;
  logic              prot;
  logic              half_locked;
  logic              awake_ok;

  level_sync #(.W(1), .RST(1'b0)) u_rst_sync (
    .i_clk   (i_clk_sys),
    .i_rst_n (i_rst_n),
    .i_d     (1'b1),
    .o_q     (rst_q)
  );

  level_sync #(.W(7), .RST(`PIN_SYNC_RST)) u_pin_sync (
    .i_clk   (i_clk_sys),
    .i_rst_n (rst_q),
    .i_d     ({i_cs_n, i_factory_lock, i_top_bottom,
               i_protect_level_bits}),
    .o_q     (pin_s)
  );

  level_sync #(.W(2), .RST(`SEC_SYNC_RST)) u_sec_sync (
    .i_clk   (i_sclk),
    .i_rst_n (i_rst_n),
    .i_d     ({cust_lock_q, fac_lock_q}),
    .o_q     (sec_l)
  );

  assign {cs_s, fac_s, tb_s, lvl_s} = pin_s;

  // Frame start flag is set by chip select itself, since the serial
  // clock may stand still between frames.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  always_comb begin
    cur_bit = first_q ? 3'h0 : bit_q;
    cur_nb  = first_q ? 3'h0 : nbyte_q;
    bit_d   = cur_bit + 3'h1;
    nbyte_d = cur_nb;
    sh_d    = {sh_q[30:0], i_si};
    op_d    = op_q;
    addr_d  = addr_q;
    if (first_q) begin
      op_d   = 8'h00;
      addr_d = 24'h000000;
    end
    if (cur_bit == 3'h7) begin
      if (cur_nb != `NBYTE_SAT) begin
        nbyte_d = cur_nb + 3'h1;
      end
      if (cur_nb == 3'h0) begin
        op_d = sh_d[7:0];
      end
      if (cur_nb == 3'h3) begin
        addr_d = sh_d[23:0];
      end
    end
  end

  // Held after the frame so the system side can read it quietly
  always_ff @(posedge i_sclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_q   <= 3'h0;
      nbyte_q <= 3'h0;
      sh_q    <= 32'h00000000;
      op_q    <= 8'h00;
      addr_q  <= 24'h000000;
    end else begin
      bit_q   <= bit_d;
      nbyte_q <= nbyte_d;
      sh_q    <= sh_d;
      op_q    <= op_d;
      addr_q  <= addr_d;
    end
  end

  always_comb begin
    sec_byte  = {6'h00, sec_l};
    so_d      = 1'b0;
    so_en_n_d = 1'b1;
    if (op_q == `OP_READ_SEC_REG && nbyte_q != 3'h0) begin
      so_d      = sec_byte[3'h7 - bit_q];
      so_en_n_d = 1'b0;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_q      <= 1'b0;
      so_en_n_q <= 1'b1;
    end else begin
      so_q      <= so_d;
      so_en_n_q <= so_en_n_d;
    end
  end

  assign o_so      = so_q;
  assign o_so_en_n = so_en_n_q;

  protect_decode u_protect (
    .i_level      (lvl_s),
    .i_top_bottom (tb_s),
    .i_block      (sn_addr_q[`BLOCK_MSB:`BLOCK_LSB]),
    .o_prot       (prot)
  );

  assign cs_rise = cs_s && !cs_prev_q;

  always_comb begin
    cs_prev_d   = cs_s;
    st_d        = st_q;
    sn_bit_d    = sn_bit_q;
    sn_nb_d     = sn_nb_q;
    sn_op_d     = sn_op_q;
    sn_addr_d   = sn_addr_q;
    wel_d       = wel_q;
    sleep_d     = sleep_q;
    secure_d    = secure_q;
    // Strap taken only once the pin synchroniser holds a real sample
    boot_d      = (boot_q == `STRAP_DONE) ? boot_q : boot_q + 2'h1;
    fac_lock_d  = (boot_q == `STRAP_CAPTURE) ? fac_s
                                             : fac_lock_q;
    cust_lock_d = cust_lock_q;
    grant_d     = '0;
    reject_d    = 1'b0;
    whole       = (sn_bit_q == 3'h0) && (sn_nb_q != 3'h0);
    half_locked = sn_addr_q[`OTP_HALF_BIT] ? fac_lock_q
                                           : cust_lock_q;
    awake_ok    = !sleep_q || sn_op_q == `OP_RELEASE_SLEEP
                  || sn_op_q == `OP_SOFT_RESET;
    if (cs_rise && st_q != wp_pkg::ST_EVAL) begin
      st_d      = wp_pkg::ST_EVAL;
      sn_bit_d  = bit_q;
      sn_nb_d   = nbyte_q;
      sn_op_d   = op_q;
      sn_addr_d = addr_q;
    end else begin
      case (st_q)
        wp_pkg::ST_STANDBY: begin
          if (!cs_s) begin
            st_d = wp_pkg::ST_FRAME;
          end
        end
        wp_pkg::ST_FRAME: begin
          st_d = wp_pkg::ST_FRAME;
        end
        wp_pkg::ST_EVAL: begin
          st_d = wp_pkg::ST_STANDBY;
          if (sn_op_q == `OP_READ_SEC_REG) begin
            reject_d = 1'b0;
          end else if (!whole || !awake_ok) begin
            reject_d = 1'b1;
          end else begin
            case (sn_op_q)
              `OP_WRITE_ENABLE:  wel_d = 1'b1;
              `OP_WRITE_DISABLE: wel_d = 1'b0;
              `OP_DEEP_SLEEP:    sleep_d = 1'b1;
              `OP_RELEASE_SLEEP: sleep_d = 1'b0;
              `OP_ENTER_SECURE:  secure_d = 1'b1;
              `OP_EXIT_SECURE:   secure_d = 1'b0;
              `OP_SOFT_RESET: begin
                wel_d    = 1'b0;
                sleep_d  = 1'b0;
                secure_d = 1'b0;
              end
              `OP_WRITE_SEC_REG: begin
                if (wel_q) begin
                  cust_lock_d = 1'b1;
                  wel_d       = 1'b0;
                end else begin
                  reject_d = 1'b1;
                end
              end
              `OP_PROGRAM: begin
                if (!wel_q || sn_nb_q != `NBYTE_SAT) begin
                  reject_d = 1'b1;
                end else if (secure_q) begin
                  if (half_locked) begin
                    reject_d = 1'b1;
                  end else begin
                    grant_d.valid = 1'b1;
                    grant_d.otp   = 1'b1;
                    grant_d.addr  = {14'h0000,
                      sn_addr_q[`OTP_ADDR_MSB:0]};
                    wel_d         = 1'b0;
                  end
                end else if (prot) begin
                  reject_d = 1'b1;
                end else begin
                  grant_d.valid = 1'b1;
                  grant_d.addr  = sn_addr_q;
                  wel_d         = 1'b0;
                end
              end
              `OP_ERASE_BLOCK: begin
                if (!wel_q || sn_nb_q != `NBYTE_ADDR_END
                    || secure_q || prot) begin
                  reject_d = 1'b1;
                end else begin
                  grant_d.valid = 1'b1;
                  grant_d.erase = 1'b1;
                  grant_d.addr  = sn_addr_q;
                  wel_d         = 1'b0;
                end
              end
              default: reject_d = 1'b1;
            endcase
          end
        end
        default: st_d = wp_pkg::ST_STANDBY;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_q) begin
    if (!rst_q) begin
      st_q        <= wp_pkg::ST_STANDBY;
      cs_prev_q   <= 1'b1;
      sn_bit_q    <= 3'h0;
      sn_nb_q     <= 3'h0;
      sn_op_q     <= 8'h00;
      sn_addr_q   <= 24'h000000;
      wel_q       <= 1'b0;
      sleep_q     <= 1'b0;
      secure_q    <= 1'b0;
      boot_q      <= 2'h0;
      fac_lock_q  <= 1'b0;
      cust_lock_q <= 1'b0;
      grant_q     <= '0;
      reject_q    <= 1'b0;
    end else begin
      st_q        <= st_d;
      cs_prev_q   <= cs_prev_d;
      sn_bit_q    <= sn_bit_d;
      sn_nb_q     <= sn_nb_d;
      sn_op_q     <= sn_op_d;
      sn_addr_q   <= sn_addr_d;
      wel_q       <= wel_d;
      sleep_q     <= sleep_d;
      secure_q    <= secure_d;
      boot_q      <= boot_d;
      fac_lock_q  <= fac_lock_d;
      cust_lock_q <= cust_lock_d;
      grant_q     <= grant_d;
      reject_q    <= reject_d;
    end
  end

  assign o_grant              = grant_q;
  assign o_reject             = reject_q;
  assign o_write_enable_latch = wel_q;
  assign o_deep_sleep         = sleep_q;
  assign o_secure_mode        = secure_q;
  assign o_security_reg       = {cust_lock_q, fac_lock_q};

  a_eval_to_standby:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      st_q == wp_pkg::ST_EVAL && !cs_rise |=> st_q == wp_pkg::ST_STANDBY)
    else $error("evaluation did not return to standby");

  a_grant_whole_bytes:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.valid |-> $past(sn_bit_q) == 3'h0)
    else $error("grant for a command not on a byte boundary");

  a_grant_needs_latch:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.valid |-> $past(wel_q) && !wel_q)
    else $error("grant without write enable latch");

  a_sleep_filter:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      sleep_q && st_q == wp_pkg::ST_EVAL
      && sn_op_q != `OP_RELEASE_SLEEP && sn_op_q != `OP_SOFT_RESET
      && sn_op_q != `OP_READ_SEC_REG
      |=> reject_q && $stable(wel_q) && $stable(secure_q))
    else $error("command accepted in deep sleep");

  a_protect_region:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.valid && !grant_q.otp |-> !$past(prot))
    else $error("grant inside protected region");

  a_level_zero_open:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      lvl_s == 4'h0 |-> !prot)
    else $error("level zero protects a block");

  a_bottom_block:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      tb_s && lvl_s != 4'h0 && sn_addr_q[23:16] == 8'h00 |-> prot)
    else $error("bottom block open with bottom protection");

  a_level_all:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      lvl_s >= 4'h9 |-> prot)
    else $error("high level leaves a block open");

  a_customer_sticky:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      cust_lock_q |=> cust_lock_q [*3])
    else $error("customer lock cleared");

  a_otp_locked_half:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.valid && grant_q.otp |-> !$past(half_locked))
    else $error("program granted into locked half");

  a_secure_no_array:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.valid && $past(secure_q) |-> grant_q.otp && !grant_q.erase)
    else $error("main array reached in secure mode");

  a_otp_offset_map:
    assert property (@(posedge i_clk_sys) disable iff (!rst_q)
      grant_q.otp |-> grant_q.addr[23:10] == 14'h0000
      && grant_q.addr[9:0] == $past(sn_addr_q[9:0]))
    else $error("secure offset not mapped");
endmodule : flash_write_guard

// *** design/level_sync.sv ***
// Two-flop synchroniser for a vector of levels
`timescale 1ns/1ps
module level_sync #(
  parameter int          W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] hold_q;
  logic [W-1:0] hold_d;

  always_comb begin
    meta_d = i_d;
    hold_d = meta_q;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST;
      hold_q <= RST;
    end else begin
      meta_q <= meta_d;
      hold_q <= hold_d;
    end
  end

  assign o_q = hold_q;
endmodule : level_sync

// *** design/protect_decode.sv ***
// Block-protect region decode from level and top/bottom select
`timescale 1ns/1ps
`include "wp_consts.svh"
module protect_decode (
  input  wire logic [3:0] i_level,
  input  wire logic       i_top_bottom,
  input  wire logic [7:0] i_block,
  output logic            o_prot
);
  logic [2:0] shift;
  logic [7:0] upper;
  logic [7:0] top_ref;

  always_comb begin
    shift   = 3'(i_level - 4'h1);
    upper   = i_block >> shift;
    top_ref = 8'hFF >> shift;
    if (i_level == 4'h0) begin
      o_prot = 1'b0;
    end else if (i_level >= `LEVEL_ALL) begin
      o_prot = 1'b1;
    end else if (i_top_bottom) begin
      o_prot = (upper == 8'h00);
    end else begin
      o_prot = (upper == top_ref);
    end
  end
endmodule : protect_decode

// *** design/wp_consts.svh ***
// Constants for the flash write-protection block
`ifndef WP_CONSTS_SVH
`define WP_CONSTS_SVH

`define OP_WRITE_ENABLE   8'h06
`define OP_WRITE_DISABLE  8'h04
`define OP_PROGRAM        8'h02
`define OP_ERASE_BLOCK    8'hD8
`define OP_DEEP_SLEEP     8'hB9
`define OP_RELEASE_SLEEP  8'hAB
`define OP_SOFT_RESET     8'h99
`define OP_ENTER_SECURE   8'hB1
`define OP_EXIT_SECURE    8'hC1
`define OP_WRITE_SEC_REG  8'h2F
`define OP_READ_SEC_REG   8'h2B

`define NBYTE_ADDR_END    3'h4
`define NBYTE_SAT         3'h5
`define LEVEL_ALL         4'h9
`define BLOCK_MSB         23
`define BLOCK_LSB         16
`define OTP_HALF_BIT      9
`define OTP_ADDR_MSB      9
`define SEC_FACTORY_BIT   0
`define SEC_CUSTOMER_BIT  1
`define PIN_SYNC_RST      7'h40
`define SEC_SYNC_RST      2'h0
`define STRAP_CAPTURE     2'h2
`define STRAP_DONE        2'h3

`endif

// *** design/wp_pkg.sv ***
// Types shared by the flash write-protection block
package wp_pkg;

  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_FRAME   = 2'b01,
    ST_EVAL    = 2'b10
  } guard_st_e;

  typedef struct packed {
    logic        valid;
    logic        erase;
    logic        otp;
    logic [23:0] addr;
  } grant_s;

endpackage : wp_pkg
